// ---- src/ccmu_pkg.sv ----
/*
   Package for the capture/compare/PWM mode unit: register offsets, field
   layout, reset values, mode codes and the carrier structs.
   Assumes one 40 MHz clock and a plain strobe register port.
*/
package ccmu_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [2:0] ADDR_CONTROL   = 3'h0; // unit_control
   localparam logic [2:0] ADDR_VALUE_LOW = 3'h1; // capture_value_low
   localparam logic [2:0] ADDR_VALUE_HI  = 3'h2; // capture_value_high
   localparam logic [2:0] ADDR_STATUS    = 3'h3; // flag and pin state
   localparam logic [2:0] ADDR_TSEL      = 3'h4; // timer select bits

   // ----------------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------------
   localparam int MODE_LSB = 0;
   localparam int DUTY_LSB = 4;
   localparam int STAT_FLAG_BIT = 0;
   localparam int STAT_PIN_BIT  = 1;
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] VALUE_RST   = 8'h00;
   localparam logic [1:0] TSEL_RST    = 2'h0;
   localparam logic [3:0] PRESC_RST   = 4'h0;
   localparam logic [3:0] PRESC_WRAP4 = 4'h3;
   localparam logic [3:0] PRESC_WRAP16 = 4'hf;

   // ----------------------------------------------------------------------
   // Mode codes
   // ----------------------------------------------------------------------
   localparam logic [3:0] MODE_OFF     = 4'h0;
   localparam logic [3:0] MODE_TOGGLE  = 4'h2;
   localparam logic [3:0] MODE_CAP_F   = 4'h4;
   localparam logic [3:0] MODE_CAP_R   = 4'h5;
   localparam logic [3:0] MODE_CAP_R4  = 4'h6;
   localparam logic [3:0] MODE_CAP_R16 = 4'h7;
   localparam logic [3:0] MODE_SET_HI  = 4'h8;
   localparam logic [3:0] MODE_SET_LO  = 4'h9;
   localparam logic [3:0] MODE_SWIRQ   = 4'ha;

   // Mode classes, one-hot
   typedef enum logic [3:0] {
      CLS_IDLE = 4'b0001,
      CLS_CAP  = 4'b0010,
      CLS_CMP  = 4'b0100,
      CLS_PWM  = 4'b1000
   } ccmu_class_e;

   // Timer counts offered to the unit
   typedef struct packed {
      logic [15:0] timerOne;   // first 16-bit timer
      logic [15:0] timerThree; // third 16-bit timer
      logic [7:0]  timerTwo;   // second 8-bit timer
      logic [7:0]  timerFour;  // fourth 8-bit timer
   } ccmu_timers_s;

   // Register port request
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ccmu_req_s;

endpackage

// ---- src/ccmu_prescaler.sv ----
/*
   Capture event qualifier: edge detection and prescaler counter.
   Assumes the pin is synchronous to clk and mode is the live mode field.
*/
`timescale 1ns/1ps
module ccmu_prescaler
   import ccmu_pkg::*;
(
   input  wire logic       clk,     // System clock
   input  wire logic       rst,     // Async reset, active high
   input  wire logic       clear,   // Clear counter
   input  wire logic [3:0] mode,    // Mode field
   input  wire logic       pinIn,   // Pin level
   output logic            capEvt   // One-cycle capture event
);

   logic       pinDly_ff;
   logic [3:0] cnt_ff;
   logic       rise;
   logic       fall;
   logic       wrapAt;

   // ----------------------------------------------------------------------
   // Edge detection
   // ----------------------------------------------------------------------
   // Any pin source counts, even a port write driving the pin
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pinDly_ff <= 1'b0;
      end else begin
         pinDly_ff <= pinIn;
      end
   end

   assign rise = pinIn & ~pinDly_ff;
   assign fall = ~pinIn & pinDly_ff;

   // ----------------------------------------------------------------------
   // Prescaler
   // ----------------------------------------------------------------------
   assign wrapAt = (mode == MODE_CAP_R16) ? (cnt_ff == PRESC_WRAP16)
                                          : (cnt_ff == PRESC_WRAP4);

   // Counter survives a change between capture settings on purpose
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= PRESC_RST;
      end else if (clear) begin
         cnt_ff <= PRESC_RST;
      end else if (rise && (mode == MODE_CAP_R4 || mode == MODE_CAP_R16))
      begin
         cnt_ff <= wrapAt ? PRESC_RST : cnt_ff + 4'h1;
      end
   end

   // Event select per capture code
   always_comb begin
      unique case (mode)
         MODE_CAP_F:   capEvt = fall;
         MODE_CAP_R:   capEvt = rise;
         MODE_CAP_R4,
         MODE_CAP_R16: capEvt = rise & wrapAt;
         default:      capEvt = 1'b0;
      endcase
   end

endmodule // ccmu_prescaler

// ---- src/ccmu_pwm.sv ----
/*
   Pulse-width output from the 10-bit duty value and an 8-bit time base.
   Assumes the timer wraps on its own; the two low duty bits extend it
   by a two-bit phase counter stepped with the time base.
*/
`timescale 1ns/1ps
module ccmu_pwm
   import ccmu_pkg::*;
(
   input  wire logic       clk,    // System clock
   input  wire logic       rst,    // Async reset, active high
   input  wire logic       enable, // PWM mode active
   input  wire logic [9:0] duty,   // Duty value
   input  wire logic [7:0] tbase,  // Selected 8-bit timer
   output logic            pwmOut  // Registered output
);

   logic [1:0] phase_ff;
   logic [7:0] tPrev_ff;

   // Fine phase advances with every step of the time base
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_ff <= 2'h0;
         tPrev_ff <= 8'h00;
      end else begin
         tPrev_ff <= tbase;
         if (!enable) begin
            phase_ff <= 2'h0;
         end else if (tbase != tPrev_ff) begin
            phase_ff <= phase_ff + 2'h1;
         end
      end
   end

   // Output high while the extended count is below the duty
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwmOut <= 1'b0;
      end else begin
         pwmOut <= enable & ({tbase, phase_ff} < duty);
      end
   end

endmodule // ccmu_pwm

// ---- src/ccmu_unit.sv ----
/*
   Capture/compare/PWM mode unit: control and data registers, time base
   selection, capture, compare and pin action.
   Assumes timer counts come from shared timers on the same clock and
   that software runs them synchronously.
*/
`timescale 1ns/1ps

module ccmu_unit
   import ccmu_pkg::*;
(
   input  wire logic          clk,        // System clock, 40 MHz
   input  wire logic          rst,        // Async reset, active high
   input  wire ccmu_req_s     req,        // Register request
   output logic [7:0]         rdata,      // Read data, cycle after read
   input  wire ccmu_timers_s  timers,     // Shared timer counts
   input  wire logic          pinIn,      // Pin level as seen
   input  wire logic          portLatch,  // Ordinary port latch level
   output logic               pinOut,     // Pin level to drive
   output logic               irqFlag     // unit_irq_flag
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic [7:0]  control_ff;
   logic [7:0]  valueLo_ff;
   logic [7:0]  valueHi_ff;
   logic [1:0]  tsel_ff;
   logic        flag_ff;
   logic        cmpLatch_ff;
   logic        match_ff;
   logic [3:0]  modePrev_ff;
   logic [3:0]  mode;
   logic [1:0]  dutyLow;
   ccmu_class_e cls;
   logic        wrCtl;
   logic        presClear;
   logic        capEvt;
   logic [15:0] ccTimer;
   logic [7:0]  pwmTimer;
   logic        useThree;
   logic        match;
   logic        matchRise;
   logic        pwmOut;
   logic        cmpFlagMode;

   assign mode    = control_ff[MODE_LSB +: 4];
   assign dutyLow = control_ff[DUTY_LSB +: 2];
   assign wrCtl   = req.wr && (req.addr == ADDR_CONTROL);

   // Mode class decode; reserved codes fall into idle
   function automatic ccmu_class_e classOf(input logic [3:0] m);
      if (m[3:2] == 2'b11) begin
         classOf = CLS_PWM;
      end else if (m[3:2] == 2'b01) begin
         classOf = CLS_CAP;
      end else if (m == MODE_TOGGLE || m == MODE_SET_HI ||
                   m == MODE_SET_LO || m == MODE_SWIRQ) begin
         classOf = CLS_CMP;
      end else begin
         classOf = CLS_IDLE;
      end
   endfunction

   assign cls     = classOf(mode);

   // ----------------------------------------------------------------------
   // Time base selection
   // ----------------------------------------------------------------------
   // Select 0 uses timers one/two only; any other value moves this unit
   // to three/four, value 3 sending every unit there
   assign useThree = (tsel_ff != TSEL_RST);
   assign ccTimer  = useThree ? timers.timerThree
                              : timers.timerOne;
   assign pwmTimer = useThree ? timers.timerFour
                              : timers.timerTwo;

   // ----------------------------------------------------------------------
   // Control and select registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         control_ff <= CONTROL_RST;
      end else if (wrCtl) begin
         control_ff <= {2'b00, req.wdata[5:0]}; // Bits 7-6 unimplemented
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tsel_ff <= TSEL_RST;
      end else if (req.wr && req.addr == ADDR_TSEL) begin
         tsel_ff <= req.wdata[1:0];
      end
   end

   // Previous mode, for entry actions
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         modePrev_ff <= MODE_OFF;
      end else begin
         modePrev_ff <= mode;
      end
   end

   // ----------------------------------------------------------------------
   // Capture
   // ----------------------------------------------------------------------
   // Clearing on leaving capture, but not on a move between settings
   assign presClear = (cls != CLS_CAP);

   ccmu_prescaler u_presc (
      .clk    (clk),
      .rst    (rst),
      .clear  (presClear),
      .mode   (mode),
      .pinIn  (pinIn),
      .capEvt (capEvt)
   );

   // Data bytes: capture overwrites silently, software write otherwise
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         valueLo_ff <= VALUE_RST;
         valueHi_ff <= VALUE_RST;
      end else if (capEvt) begin
         valueLo_ff <= ccTimer[7:0];
         valueHi_ff <= ccTimer[15:8];
      end else if (req.wr) begin
         if (req.addr == ADDR_VALUE_LOW) begin
            valueLo_ff <= req.wdata;
         end
         if (req.addr == ADDR_VALUE_HI) begin
            valueHi_ff <= req.wdata;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Compare
   // ----------------------------------------------------------------------
   assign match = (cls == CLS_CMP) &&
                  ({valueHi_ff, valueLo_ff} == ccTimer);

   // Act once per match: the timer may hold a value many clocks
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         match_ff <= 1'b0;
      end else begin
         match_ff <= match;
      end
   end

   assign matchRise   = match & ~match_ff;
   assign cmpFlagMode = (cls == CLS_CMP);

   // Compare output latch with entry values
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmpLatch_ff <= 1'b0;
      end else if (mode == MODE_OFF) begin
         cmpLatch_ff <= 1'b0;
      end else if (mode != modePrev_ff && mode == MODE_SET_HI) begin
         cmpLatch_ff <= 1'b0;
      end else if (mode != modePrev_ff && mode == MODE_SET_LO) begin
         cmpLatch_ff <= 1'b1;
      end else if (matchRise) begin
         unique case (mode)
            MODE_TOGGLE: cmpLatch_ff <= ~cmpLatch_ff;
            MODE_SET_HI: cmpLatch_ff <= 1'b1;
            MODE_SET_LO: cmpLatch_ff <= 1'b0;
            default:     cmpLatch_ff <= cmpLatch_ff;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Interrupt flag
   // ----------------------------------------------------------------------
   // Set wins over a software clear in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flag_ff <= 1'b0;
      end else if (capEvt || (matchRise && cmpFlagMode)) begin
         flag_ff <= 1'b1;
      end else if (req.wr && req.addr == ADDR_STATUS &&
                   !req.wdata[STAT_FLAG_BIT]) begin
         flag_ff <= 1'b0;
      end
   end

   assign irqFlag = flag_ff;

   // ----------------------------------------------------------------------
   // Pulse width and pin
   // ----------------------------------------------------------------------
   ccmu_pwm u_pwm (
      .clk    (clk),
      .rst    (rst),
      .enable (cls == CLS_PWM),
      .duty   ({valueLo_ff, dutyLow}),
      .tbase  (pwmTimer),
      .pwmOut (pwmOut)
   );

   // Pin source per class; idle and 1010 leave the port latch in charge
   always_comb begin
      unique case (cls)
         CLS_PWM: pinOut = pwmOut;
         CLS_CMP: pinOut = (mode == MODE_SWIRQ) ? portLatch
                                                : cmpLatch_ff;
         default: pinOut = portLatch;
      endcase
   end

   // ----------------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (req.rd) begin
         unique case (req.addr)
            ADDR_CONTROL:   rdata <= control_ff;
            ADDR_VALUE_LOW: rdata <= valueLo_ff;
            ADDR_VALUE_HI:  rdata <= valueHi_ff;
            ADDR_STATUS:    rdata <= {6'h00, pinOut, flag_ff};
            ADDR_TSEL:      rdata <= {6'h00, tsel_ff};
            default:        rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

endmodule // ccmu_unit

// ---- sim/ccmu_properties.sv ----
/*
   Checker on the mode unit ports, bound after the module.
   Assumes software rewrites both data bytes before any compare mode.
*/
`timescale 1ns/1ps
module ccmu_properties
   import ccmu_pkg::*;
(
   input wire logic         clk,       // Clock
   input wire logic         rst,       // Reset
   input wire ccmu_req_s    req,       // Request
   input wire logic [7:0]   rdata,     // Read data
   input wire ccmu_timers_s timers,    // Timers
   input wire logic         pinIn,     // Pin in
   input wire logic         portLatch, // Port latch
   input wire logic         pinOut,    // Pin out
   input wire logic         irqFlag    // Flag
);
   // ------------------------------------------------------
   // Shadow of software writes
   // ------------------------------------------------------
   logic [7:0] ctrlFf, loFf, hiFf, ctrlRb;
   logic       tselFf, matchFf, idle, match;
   logic [3:0] modeNow;
   default clocking cbMain @(posedge clk); endclocking
   default disable iff (rst);
   assign modeNow = ctrlFf[3:0];
   assign ctrlRb = {2'b00, ctrlFf[5:0]};
   assign idle = modeNow inside {MODE_OFF, 4'h1, 4'h3, 4'hb};
   // Stale after a capture, so only compare checks lean on it
   assign match = {hiFf, loFf} == (tselFf ? timers.timerThree
                                          : timers.timerOne);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrlFf <= 8'h00;
         loFf <= 8'h00;
         hiFf <= 8'h00;
         tselFf <= 1'b0;
         matchFf <= 1'b0;
      end else begin
         matchFf <= match;
         if (req.wr && req.addr == ADDR_CONTROL) ctrlFf <= req.wdata;
         if (req.wr && req.addr == ADDR_VALUE_LOW) loFf <= req.wdata;
         if (req.wr && req.addr == ADDR_VALUE_HI) hiFf <= req.wdata;
         if (req.wr && req.addr == ADDR_TSEL) tselFf <= |req.wdata[1:0];
      end
   end
   // ------------------------------------------------------
   // Properties
   // ------------------------------------------------------
   sequence sIdle3;
      (idle && !req.wr) [*3];
   endsequence
   sequence sEntry;
      req.wr && req.addr == ADDR_CONTROL && req.wdata[3:1] == 3'b100;
   endsequence
   sequence sMatchHi;
      modeNow == MODE_SET_HI && match && !matchFf;
   endsequence
   AST_RD_IDLE: assert property (!req.rd |=> rdata == 8'h00)
      else $error("read data outside read slot");
   AST_CTRL_RB: assert property (
      req.rd && req.addr == ADDR_CONTROL |=> rdata == $past(ctrlRb))
      else $error("control readback wrong");
   AST_FLAG_HOLD: assert property (irqFlag && !req.wr |=> irqFlag)
      else $error("flag cleared by hardware");
   AST_CAP_RISE: assert property (
      modeNow == MODE_CAP_R && $rose(pinIn) |-> ##[1:3] irqFlag)
      else $error("rising edge not captured");
   AST_CAP_FALL: assert property (
      modeNow == MODE_CAP_F && $fell(pinIn) |-> ##[1:3] irqFlag)
      else $error("falling edge not captured");
   AST_PORT_PIN: assert property (
      idle || modeNow == MODE_SWIRQ |-> pinOut == portLatch)
      else $error("pin not following port latch");
   AST_IDLE_FLAG: assert property (
      sIdle3 ##0 !irqFlag |=> !irqFlag)
      else $error("flag set while idle");
   AST_ENTRY: assert property (
      sEntry |=> ##1 pinOut == $past(req.wdata[0], 2))
      else $error("entry level wrong");
   AST_CMP_HI: assert property (
      sMatchHi |-> ##[1:2] pinOut && irqFlag)
      else $error("compare match not acted on");
endmodule // ccmu_properties

bind ccmu_unit ccmu_properties i_ccmu_properties (.clk(clk), .rst(rst),
   .req(req), .rdata(rdata), .timers(timers), .pinIn(pinIn),
   .portLatch(portLatch), .pinOut(pinOut), .irqFlag(irqFlag));

// ---- sim/ccmu_env_model.sv ----
/*
   Far side model: shared timer counts and the event pin.
   Assumes the bench drives run and pinCmd just after rising edges.
*/
`timescale 1ns/1ps
module ccmu_env_model
   import ccmu_pkg::*;
(
   input  wire logic    clk,    // Clock
   input  wire logic    rst,    // Reset
   input  wire logic    run,    // Timers count
   input  wire logic    pinCmd, // Wanted pin level
   output ccmu_timers_s timers, // Timer counts
   output logic         pinIn   // Pin level
);
   // ------------------------------------------------------
   // Timers and pin
   // ------------------------------------------------------
   logic [15:0] cntFf;
   // Counting on clk only keeps captured values settled
   always_ff @(posedge clk or posedge rst) begin
      if (rst) cntFf <= 16'h0000;
      else if (run) cntFf <= cntFf + 16'h0001;
   end
   // Distinct offsets so a wrong timer choice shows
   assign timers = {cntFf + 16'h0123, cntFf + 16'h8a50, cntFf[7:0],
                    cntFf[7:0] ^ 8'h80};
   // Pin is an input driven from outside only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) pinIn <= 1'b0;
      else pinIn <= pinCmd;
   end
endmodule // ccmu_env_model

// ---- sim/tb_top.sv ----
/*
   Self-checking bench for the mode unit with a register shadow model.
   Assumes read data one cycle after the strobe and no wait states.
*/
`timescale 1ns/1ps
module tb_top
   import ccmu_pkg::*;
;
   logic         clk, rst, run, pinCmd, portLatch, pinIn, pinOut, irqFlag;
   ccmu_req_s    req;
   ccmu_timers_s timers;
   logic [7:0]   rdata;
   logic [31:0]  seed;
   int           numErrors, checks, cycles;
   int           shadow [8];
   logic [3:0]   cmpModes [8] = '{4'h2, 4'h8, 4'h9, 4'ha,
                                  4'h0, 4'h1, 4'h3, 4'hb};

   ccmu_unit i_ccmu_unit (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
      .timers(timers), .pinIn(pinIn), .portLatch(portLatch),
      .pinOut(pinOut), .irqFlag(irqFlag));
   ccmu_env_model i_ccmu_env_model (.clk(clk), .rst(rst), .run(run),
      .pinCmd(pinCmd), .timers(timers), .pinIn(pinIn));

   // ------------------------------------------------------
   // Clock, timeout and helpers
   // ------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Whole run needs about 2000 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 12000) begin
         numErrors++;
         wrapUp();
      end
   end
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         numErrors++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
      case (a)
         3'h0: shadow[0] = d & 8'h3f;
         3'h1, 3'h2: shadow[a] = d;
         3'h4: shadow[4] = d & 8'h03;
         default: ;
      endcase
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '0;
      #1 v = rdata;
      @(posedge clk);
   endtask
   task automatic cr(input logic [2:0] a);
      logic [7:0] v;
      rd(a, v);
      chk(v, 8'(shadow[a]));
   endtask
   task automatic flag(input logic e);
      logic [7:0] v;
      rd(ADDR_STATUS, v);
      chk(v & 8'h01, {7'h00, e});
   endtask
   task automatic edges(input int n);
      repeat (n) begin
         pinCmd <= 1'b1;
         repeat (3) @(posedge clk);
         pinCmd <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
   task automatic regsAll();
      for (int a = 0; a < 8; a++) if (a != 3) cr(3'(a));
      $display("register pass done");
   endtask
   task automatic pwmCount(output int hi);
      hi = 0;
      repeat (300) begin
         @(negedge clk);
         hi += int'(pinOut);
      end
      @(posedge clk);
   endtask
   task automatic wrapUp();
      $display("checks %0d mismatches %0d", checks, numErrors);
      if (numErrors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------
   initial begin
      logic [15:0] t;
      logic [7:0]  v;
      logic        p, e;
      int          n, hi;
      req = '0;
      run = 1'b0;
      pinCmd = 1'b0;
      portLatch = 1'b0;
      rst = 1'b1;
      seed = 32'h1a16;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      regsAll();
      wr(ADDR_CONTROL, 8'hff);
      wr(ADDR_VALUE_LOW, rnd());
      wr(ADDR_VALUE_HI, rnd());
      wr(3'h6, rnd());
      wr(ADDR_TSEL, rnd());
      regsAll();
      // Capture in every mode on both timer choices
      for (int s = 0; s < 2; s++) begin
         for (int m = 4; m < 8; m++) begin
            n = (m == 6) ? 4 : (m == 7) ? 16 : 1;
            wr(ADDR_TSEL, 8'(s));
            wr(ADDR_CONTROL, 8'h00);
            wr(ADDR_STATUS, 8'h00);
            wr(ADDR_CONTROL, 8'(m));
            run <= 1'b1;
            repeat (8 + rnd() % 32) @(posedge clk);
            run <= 1'b0;
            @(posedge clk);
            t = s ? timers.timerThree : timers.timerOne;
            edges(n - 1);
            flag(1'b0);
            pinCmd <= 1'b1;
            repeat (4) @(posedge clk);
            flag(m != 4);
            pinCmd <= 1'b0;
            repeat (4) @(posedge clk);
            flag(1'b1);
            shadow[1] = t[7:0];
            shadow[2] = t[15:8];
            cr(3'h1);
            cr(3'h2);
         end
      end
      $display("capture modes done");
      // Second capture overwrites the first with flag still set
      run <= 1'b1;
      repeat (20) @(posedge clk);
      run <= 1'b0;
      @(posedge clk);
      t = timers.timerThree;
      wr(ADDR_CONTROL, 8'h05);
      edges(1);
      shadow[1] = t[7:0];
      shadow[2] = t[15:8];
      cr(3'h1);
      cr(3'h2);
      // Direct prescaler switch keeps the partial count
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_CONTROL, 8'h06);
      edges(2);
      wr(ADDR_CONTROL, 8'h07);
      wr(ADDR_STATUS, 8'h00);
      edges(13);
      flag(1'b0);
      edges(1);
      flag(1'b1);
      $display("overwrite and prescaler done");
      // Compare, software interrupt and reserved codes
      foreach (cmpModes[i]) begin
         wr(ADDR_CONTROL, 8'h00);
         wr(ADDR_TSEL, {7'h00, i[0]});
         t = i[0] ? timers.timerThree : timers.timerOne;
         t = t + 16'h0028;
         wr(ADDR_VALUE_LOW, t[7:0]);
         wr(ADDR_VALUE_HI, t[15:8]);
         wr(ADDR_STATUS, 8'h00);
         v = rnd();
         portLatch <= v[0];
         wr(ADDR_CONTROL, {4'h0, cmpModes[i]});
         #1 p = pinOut;
         // Entry level: mode 0 left the compare latch low
         case (cmpModes[i])
            4'h2, 4'h8: e = 1'b0;
            4'h9: e = 1'b1;
            default: e = portLatch;
         endcase
         chk({7'h00, p}, {7'h00, e});
         @(posedge clk);
         run <= 1'b1;
         repeat (60) @(posedge clk);
         run <= 1'b0;
         @(posedge clk);
         case (cmpModes[i])
            4'h2: e = 1'b1;
            4'h8: e = 1'b1;
            4'h9: e = 1'b0;
            default: e = portLatch;
         endcase
         chk({7'h00, pinOut}, {7'h00, e});
         flag(i < 4);
      end
      $display("compare modes done");
      // Pulse width extremes of the ten-bit duty
      wr(ADDR_VALUE_LOW, 8'h00);
      wr(ADDR_CONTROL, 8'h0c);
      run <= 1'b1;
      pwmCount(hi);
      chk(8'(hi < 3), 8'h01);
      wr(ADDR_VALUE_LOW, 8'hff);
      wr(ADDR_CONTROL, 8'h3c);
      pwmCount(hi);
      chk(8'(hi > 200), 8'h01);
      run <= 1'b0;
      $display("pulse width done");
      // Reset in mid-run returns every register to zero
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      foreach (shadow[k]) shadow[k] = 0;
      @(posedge clk);
      regsAll();
      flag(1'b0);
      wrapUp();
   end
endmodule // tb_top
